/* inc/stli_pkg.sv */
/*
  Constants shared by the status latch and interrupt block: register
  select codes on the host port, alarm bit layouts and reset values.
  Assumes one 100 MHz system clock for all logic that uses it.
*/
package stli_pkg;

  // Register select codes presented on host_sel
  localparam logic [2:0] STLI_SEL_STATUS_A = 3'h0;
  localparam logic [2:0] STLI_SEL_STATUS_B = 3'h1;
  localparam logic [2:0] STLI_SEL_RX_INFO = 3'h2;
  localparam logic [2:0] STLI_SEL_SYNC_STATE = 3'h3;
  localparam logic [2:0] STLI_SEL_HDLC_STATUS = 3'h4;

  // Bit positions inside status_reg_a
  localparam int STLI_A_SIG_ALL_ONES = 7;
  localparam int STLI_A_DISTANT_MF = 6;
  localparam int STLI_A_SIG_ALL_ZEROS = 5;
  localparam int STLI_A_RX_SLIP = 4;
  localparam int STLI_A_UNFRAMED_ONES = 3;
  localparam int STLI_A_REMOTE = 2;
  localparam int STLI_A_CARRIER_LOSS = 1;
  localparam int STLI_A_FRAME_UNLOCKED = 0;

  // Which bits of each latched register are alarms (level sources)
  localparam logic [7:0] STLI_ALARMS_A = 8'h0F;
  localparam logic [7:0] STLI_ALARMS_NONE = 8'h00;

  // Reset values
  localparam logic [7:0] STLI_BYTE_RST = 8'h00;
  localparam logic STLI_INT_N_RST = 1'b1;

endpackage : stli_pkg

/* src/stli_latch_byte.sv */
/*
  One latched status byte: sticky bits, masked readable copy,
  clear on read, and per-bit interrupt pending with masking.
  Assumes set_in comes from logic on clk_sys: event bits are pulses,
  alarm bits (ALARM_BITS) are levels that stay high while present.
*/
`timescale 1ns/10ps

module stli_latch_byte #(
  parameter logic [7:0] ALARM_BITS = 8'h00
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [7:0] set_in,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [7:0] wdata,
  input wire logic [7:0] irq_mask,
  output logic [7:0] copy_q,
  output logic irq_q
);
  import stli_pkg::*;

  logic [7:0] lat_ff, nxt_lat;
  logic [7:0] copy_ff, nxt_copy;
  logic [7:0] sel_ff, nxt_sel;
  logic [7:0] prev_ff, nxt_prev;
  logic [7:0] apend_ff, nxt_apend;
  logic irq_ff, nxt_irq;
  logic [7:0] rd_clr;
  logic [7:0] chg;

  // Next state; every set beats a clear landing in the same cycle
  always_comb begin
    rd_clr = rd_stb ? (sel_ff & copy_ff) : STLI_BYTE_RST;
    chg = (set_in ^ prev_ff) & ALARM_BITS;
    // Alarm level re-sets the bit at once if still present
    nxt_lat = (lat_ff & ~rd_clr) | set_in;
    // Only the masked positions take fresh values
    nxt_copy = wr_stb ? ((wdata & lat_ff) | (~wdata & copy_ff))
                      : copy_ff;
    // A second read without a new mask clears nothing
    nxt_sel = wr_stb ? wdata : (rd_stb ? STLI_BYTE_RST : sel_ff);
    nxt_prev = set_in & ALARM_BITS;
    // Alarm change pends until the reading of that bit
    nxt_apend = (apend_ff & ~rd_clr) | chg;
    // Event bits pend while latched, alarm bits while a change pends
    nxt_irq = |(((lat_ff & ~ALARM_BITS) | apend_ff)
                & irq_mask);
  end

  // Registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      lat_ff <= STLI_BYTE_RST;
      copy_ff <= STLI_BYTE_RST;
      sel_ff <= STLI_BYTE_RST;
      prev_ff <= STLI_BYTE_RST;
      apend_ff <= STLI_BYTE_RST;
      irq_ff <= 1'b0;
    end else begin
      lat_ff <= nxt_lat;
      copy_ff <= nxt_copy;
      sel_ff <= nxt_sel;
      prev_ff <= nxt_prev;
      apend_ff <= nxt_apend;
      irq_ff <= nxt_irq;
    end
  end

  assign copy_q = copy_ff;
  assign irq_q = irq_ff;

endmodule // stli_latch_byte

/* src/stli_status_irq.sv */
/*
  Status latch and interrupt block of an E1 framer: four latched
  status bytes, a live synchronizer byte, a byte-wide host access port
  and the active-low interrupt output.
  Assumes framer sources and host strobes are already on clk_sys.
*/
// What this block does
// - Events and alarms latch their status bit
// - Reading a latched bit clears it
// - Present alarms stay set after a read
// - Mask one loads latest bit into copy
// - Mask zero holds previous copy bit
// - Sync state byte is live and read-only
// - Only A, B and HDLC bytes interrupt
// - Each interrupt source has its mask bit
// - Alarm change either way raises interrupt
// - Reading the alarm bit releases its interrupt; a fall in the clearing read's cycle stays pending
// - Event occurrence raises interrupt when unmasked
// - Reading the event bit releases its interrupt
// - Signaling, slip, multiframe, timer bits are events
`timescale 1ns/10ps

module stli_status_irq (
  input wire logic clk_sys,
  input wire logic rst_n,
  // Alarm levels of status_reg_a
  input wire logic rx_unframed_ones_alarm,
  input wire logic rx_remote_alarm,
  input wire logic rx_carrier_loss_alarm,
  input wire logic rx_frame_unlocked_alarm,
  // Event pulses of status_reg_a
  input wire logic rx_sig_all_ones_event,
  input wire logic rx_distant_mf_event,
  input wire logic rx_sig_all_zeros_event,
  input wire logic rx_slip_event,
  // Event pulses of status_reg_b, rx_info_reg, hdlc_status_reg
  input wire logic [7:0] status_b_events,
  input wire logic [7:0] rx_info_events,
  input wire logic [7:0] hdlc_events,
  // Live synchronizer state
  input wire logic [7:0] sync_state_in,
  // Interrupt masks, one enables the source
  input wire logic [7:0] mask_reg_a,
  input wire logic [7:0] mask_reg_b,
  input wire logic [7:0] hdlc_mask_reg,
  // Host access port
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [2:0] host_sel,
  input wire logic [7:0] host_wdata,
  output logic [7:0] host_rdata,
  output logic host_rvalid,
  output logic int_n
);
  import stli_pkg::*;

  logic [7:0] set_a;
  logic [3:0] wr_hit, rd_hit;
  logic [7:0] copy_a, copy_b, copy_r, copy_h;
  logic irq_a, irq_b, irq_h;
  logic [7:0] rdata_ff, nxt_rdata;
  logic rvalid_ff, nxt_rvalid;
  logic int_n_ff, nxt_int_n;

  // Gather status_reg_a; alarms sit in the low nibble as levels
  always_comb begin
    set_a = STLI_BYTE_RST;
    set_a[STLI_A_SIG_ALL_ONES] = rx_sig_all_ones_event;
    set_a[STLI_A_DISTANT_MF] = rx_distant_mf_event;
    set_a[STLI_A_SIG_ALL_ZEROS] = rx_sig_all_zeros_event;
    set_a[STLI_A_RX_SLIP] = rx_slip_event;
    set_a[STLI_A_UNFRAMED_ONES] = rx_unframed_ones_alarm;
    set_a[STLI_A_REMOTE] = rx_remote_alarm;
    set_a[STLI_A_CARRIER_LOSS] = rx_carrier_loss_alarm;
    set_a[STLI_A_FRAME_UNLOCKED] = rx_frame_unlocked_alarm;
  end

  // Decode host strobes; writes to the sync byte are dropped
  always_comb begin
    wr_hit = 4'h0;
    rd_hit = 4'h0;
    case (host_sel)
      STLI_SEL_STATUS_A: begin
        wr_hit[0] = host_wr;
        rd_hit[0] = host_rd;
      end
      STLI_SEL_STATUS_B: begin
        wr_hit[1] = host_wr;
        rd_hit[1] = host_rd;
      end
      STLI_SEL_RX_INFO: begin
        wr_hit[2] = host_wr;
        rd_hit[2] = host_rd;
      end
      STLI_SEL_HDLC_STATUS: begin
        wr_hit[3] = host_wr;
        rd_hit[3] = host_rd;
      end
      default: begin
        wr_hit = 4'h0;
        rd_hit = 4'h0;
      end
    endcase
  end

  // Latched bytes; rx_info_reg gets a zero mask so it never interrupts
  stli_latch_byte #(.ALARM_BITS(STLI_ALARMS_A)) u_stat_a (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .set_in(set_a),
    .wr_stb(wr_hit[0]),
    .rd_stb(rd_hit[0]),
    .wdata(host_wdata),
    .irq_mask(mask_reg_a),
    .copy_q(copy_a),
    .irq_q(irq_a)
  );

  stli_latch_byte #(.ALARM_BITS(STLI_ALARMS_NONE)) u_stat_b (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .set_in(status_b_events),
    .wr_stb(wr_hit[1]),
    .rd_stb(rd_hit[1]),
    .wdata(host_wdata),
    .irq_mask(mask_reg_b),
    .copy_q(copy_b),
    .irq_q(irq_b)
  );

  stli_latch_byte #(.ALARM_BITS(STLI_ALARMS_NONE)) u_rx_info (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .set_in(rx_info_events),
    .wr_stb(wr_hit[2]),
    .rd_stb(rd_hit[2]),
    .wdata(host_wdata),
    .irq_mask(STLI_BYTE_RST),
    .copy_q(copy_r),
    .irq_q()
  );

  stli_latch_byte #(.ALARM_BITS(STLI_ALARMS_NONE)) u_hdlc (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .set_in(hdlc_events),
    .wr_stb(wr_hit[3]),
    .rd_stb(rd_hit[3]),
    .wdata(host_wdata),
    .irq_mask(hdlc_mask_reg),
    .copy_q(copy_h),
    .irq_q(irq_h)
  );

  // Read mux and interrupt pin; sync byte bypasses any latch
  always_comb begin
    nxt_rdata = rdata_ff;
    nxt_rvalid = host_rd;
    if (host_rd) begin
      case (host_sel)
        STLI_SEL_STATUS_A: nxt_rdata = copy_a;
        STLI_SEL_STATUS_B: nxt_rdata = copy_b;
        STLI_SEL_RX_INFO: nxt_rdata = copy_r;
        STLI_SEL_SYNC_STATE: nxt_rdata = sync_state_in;
        STLI_SEL_HDLC_STATUS: nxt_rdata = copy_h;
        default: nxt_rdata = STLI_BYTE_RST;
      endcase
    end
    // irq_r is left out on purpose; that byte has no interrupt path
    nxt_int_n = ~(irq_a | irq_b | irq_h);
  end

  // Output registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= STLI_BYTE_RST;
      rvalid_ff <= 1'b0;
      int_n_ff <= STLI_INT_N_RST;
    end else begin
      rdata_ff <= nxt_rdata;
      rvalid_ff <= nxt_rvalid;
      int_n_ff <= nxt_int_n;
    end
  end

  assign host_rdata = rdata_ff;
  assign host_rvalid = rvalid_ff;
  assign int_n = int_n_ff;

endmodule // stli_status_irq

/* verif/stli_host_model.sv */
/* Host processor model: mask write, read, write-back on the host port.
   Assumes strobes are taken on the rising edge of clk_sys. */
`timescale 1ns/10ps
module stli_host_model (
  input wire logic clk_sys,
  output logic host_wr,
  output logic host_rd,
  output logic [2:0] host_sel,
  output logic [7:0] host_wdata,
  input wire logic [7:0] host_rdata,
  input wire logic host_rvalid
);
  initial begin
    host_wr = 1'b0;
    host_rd = 1'b0;
    host_sel = 3'h0;
    host_wdata = 8'h00;
  end
  // One polled access; idle data is inverted so it never looks valid
  task automatic xfer(input logic [2:0] s, input logic [7:0] m,
                      input logic w);
    int i;
    @(negedge clk_sys);
    host_sel = s;
    if (w) begin
      host_wr = 1'b1;
      host_wdata = m;
      @(negedge clk_sys);
      host_wr = 1'b0;
    end
    host_rd = 1'b1;
    @(negedge clk_sys);
    host_rd = 1'b0;
    for (i = 0; i < 4 && host_rvalid !== 1'b1; i++) @(negedge clk_sys);
    if (w) begin
      host_wr = 1'b1;
      host_wdata = host_rdata & m;
      @(negedge clk_sys);
    end
    host_wr = 1'b0;
    host_wdata = ~host_wdata;
  endtask
endmodule // stli_host_model

/* verif/stli_chk_assertions.sv */
/* Port checker for the status latch and interrupt block.
   Assumes a single clk_sys domain with rst_n active low. */
`timescale 1ns/10ps
module stli_chk import stli_pkg::*; (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic host_rd,
  input wire logic [2:0] host_sel,
  input wire logic [7:0] sync_state_in,
  input wire logic [7:0] host_rdata,
  input wire logic host_rvalid,
  input wire logic int_n,
  input wire logic [7:0] mask_reg_a,
  input wire logic [7:0] mask_reg_b,
  input wire logic [7:0] hdlc_mask_reg,
  input wire logic rx_slip_event,
  input wire logic rx_remote_alarm
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // Masks must all stay zero for three edges before the pin is judged
  sequence s_quiet;
    (mask_reg_a == 0 && mask_reg_b == 0 && hdlc_mask_reg == 0)[*3];
  endsequence
  sequence s_int_low;
    ##[1:3] !int_n;
  endsequence
  AST_RV: assert property (host_rd |=> host_rvalid)
    else $error("read gave no rvalid");
  AST_NORV: assert property (!host_rd |=> !host_rvalid)
    else $error("rvalid without read");
  AST_HOLD: assert property (!host_rd |=> $stable(host_rdata))
    else $error("rdata moved without read");
  AST_SYNC: assert property (host_rd && host_sel == STLI_SEL_SYNC_STATE
    |=> host_rdata == $past(sync_state_in))
    else $error("sync byte not live");
  AST_UNMAP: assert property (host_rd && host_sel > 3'h4
    |=> host_rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_RST: assert property ($rose(rst_n) |-> int_n && !host_rvalid)
    else $error("not idle after reset");
  AST_MASK: assert property (s_quiet |=> int_n)
    else $error("masked source drove int_n");
  AST_EVT: assert property (rx_slip_event && mask_reg_a[4]
    |-> s_int_low)
    else $error("event did not interrupt");
  AST_ALARM: assert property ($changed(rx_remote_alarm) && $past(rst_n)
    && mask_reg_a[2] |-> s_int_low)
    else $error("alarm change did not interrupt");
endmodule // stli_chk
bind stli_status_irq stli_chk chk_u (.clk_sys, .rst_n, .host_rd,
  .host_sel, .sync_state_in, .host_rdata, .host_rvalid, .int_n,
  .mask_reg_a, .mask_reg_b, .hdlc_mask_reg, .rx_slip_event,
  .rx_remote_alarm);

/* verif/stli_status_irq_bench.sv */
/* Self-checking bench for the status latch and interrupt block.
   Assumes the host model and the bound checker are compiled first. */
`timescale 1ns/10ps
module stli_status_irq_bench;
  import stli_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] al = 4'h0;
  logic [7:0] ev_a = 8'h00, ev_b = 8'h00, ev_i = 8'h00, ev_h = 8'h00;
  logic [7:0] sync_in = 8'h00, r;
  logic [7:0] mask_reg_a = 8'h00, mask_reg_b = 8'h00;
  logic [7:0] hdlc_mask_reg = 8'h00, host_wdata, host_rdata;
  logic host_wr, host_rd, host_rvalid, int_n;
  logic [2:0] host_sel;
  logic [7:0] exp_q[$];
  int err_total = 0;
  int n_checks = 0;
  int sl[4] = '{0, 1, 2, 4};
  always #5 clk_sys = ~clk_sys;
  stli_status_irq dut_u (.clk_sys, .rst_n,
    .rx_unframed_ones_alarm(al[3]), .rx_remote_alarm(al[2]),
    .rx_carrier_loss_alarm(al[1]), .rx_frame_unlocked_alarm(al[0]),
    .rx_sig_all_ones_event(ev_a[7]), .rx_distant_mf_event(ev_a[6]),
    .rx_sig_all_zeros_event(ev_a[5]), .rx_slip_event(ev_a[4]),
    .status_b_events(ev_b), .rx_info_events(ev_i), .hdlc_events(ev_h),
    .sync_state_in(sync_in), .mask_reg_a, .mask_reg_b, .hdlc_mask_reg,
    .host_wr, .host_rd, .host_sel, .host_wdata, .host_rdata,
    .host_rvalid, .int_n);
  stli_host_model host_u (.clk_sys, .host_wr, .host_rd, .host_sel,
    .host_wdata, .host_rdata, .host_rvalid);
  task automatic chk(input string nm, input logic [7:0] seen,
                     input logic [7:0] ex);
    n_checks++;
    if (seen !== ex) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, ex, seen);
    end
  endtask
  task automatic ci(input logic e);
    chk("int_n", {7'h00, int_n}, {7'h00, e});
  endtask
  task automatic stop_test;
    // A read that never answered leaves its note behind
    chk("pending reads", 8'(exp_q.size()), 8'h00);
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // One-cycle event pulse on the chosen byte
  task automatic pulse(input int s, input logic [7:0] v);
    @(negedge clk_sys);
    case (s)
      0: ev_a = v;
      1: ev_b = v;
      2: ev_i = v;
      default: ev_h = v;
    endcase
    @(negedge clk_sys);
    {ev_a, ev_b, ev_i, ev_h} = '0;
  endtask
  task automatic rd(input int s, input logic [7:0] m, input logic [7:0] e);
    exp_q.push_back(e);
    host_u.xfer(3'(s), m, 1'b1);
  endtask
  task automatic idle;
    repeat (4) @(negedge clk_sys);
  endtask
  // Read results are matched against the oldest expectation;
  // sampled mid-cycle so the registered outputs have settled
  always @(negedge clk_sys) begin
    if (host_rvalid === 1'b1) begin
      if (exp_q.size() == 0) chk("rvalid", 8'h01, 8'h00);
      else chk("rdata", host_rdata, exp_q.pop_front());
    end
  end
  initial begin
    void'($urandom(51));
    repeat (4) @(negedge clk_sys);
    rst_n = 1'b1;
    ci(1'b1);
    {mask_reg_a, mask_reg_b, hdlc_mask_reg} = '1;
    foreach (sl[k]) begin
      r = 8'($urandom) | 8'h10;
      if (sl[k] == 0) r = r & 8'hF0;
      pulse(sl[k], r);
      idle;
      ci(sl[k] == 2);
      rd(sl[k], 8'hFF, r);
      idle;
      ci(1'b1);
      rd(sl[k], 8'hFF, 8'h00);
    end
    $display("latch test done");
    al = 4'hF;
    idle;
    ci(1'b0);
    rd(0, 8'h0F, 8'h0F);
    idle;
    ci(1'b1);
    rd(0, 8'h0F, 8'h0F);
    al = 4'h0;
    idle;
    ci(1'b0);
    rd(0, 8'h0F, 8'h0F);
    idle;
    ci(1'b1);
    rd(0, 8'h0F, 8'h00);
    $display("alarm test done");
    {mask_reg_a, mask_reg_b, hdlc_mask_reg} = '0;
    r = 8'($urandom) | 8'h11;
    pulse(1, r);
    idle;
    ci(1'b1);
    rd(1, 8'h0F, r & 8'h0F);
    pulse(1, r);
    rd(1, 8'hF0, r & 8'hF0);
    rd(1, 8'h0F, r & 8'h0F);
    $display("mask test done");
    sync_in = 8'($urandom);
    exp_q.push_back(sync_in);
    host_u.xfer(STLI_SEL_SYNC_STATE, 8'h00, 1'b0);
    exp_q.push_back(8'h00);
    host_u.xfer(3'h5, 8'h00, 1'b0);
    idle;
    $display("sync test done");
    stop_test;
  end
  // Hang guard, far beyond the roughly 140 cycles the tests need
  initial begin
    #100000;
    err_total++;
    stop_test;
  end
endmodule // stli_status_irq_bench
